// *** rtl/flg_guard.sv ***
// flg_guard: flash access guard with AHB-Lite registers and flash-error reset request
// assumes the core presents one flash access at a time with a valid pulse and exec page
//
// Summary of operation
// - unlocked code: unlocked pages fully accessible
// - unlocked code: locked pages refused
// - unlocked code: lock page only if unlocked
// - locked code: all pages except lock page
// - locked code: lock page read/write, no erase
// - lock page erase blocked, error reset only while write enable is set
// - lock byte always readable
// - no further pages may be locked
// - no pages may be unlocked
// - reserved/forbidden access causes error reset, except writes while write enable is off
`timescale 1ns/1ps
`include "flg_defs.svh"
module flg_guard #(
    // lock byte image loaded at reset; bit n low locks page n
    parameter logic [7:0] LOCK_IMAGE = `FLG_LOCK_RST,
    parameter int         NUM_EV     = `FLG_NUM_EV
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              acc_valid,
    input  wire logic              acc_is_write,
    input  wire flg_pkg::flg_addr_t acc_addr,
    input  wire logic [7:0]        acc_wdata,
    input  wire flg_pkg::flg_page_t exec_page,
    output logic                   acc_done,
    output logic                   acc_granted,
    output logic                   acc_is_erase,
    output flg_pkg::flg_addr_t     flash_addr,
    output logic [7:0]             flash_wdata,
    output logic                   flash_rd,
    output logic                   flash_wr,
    output logic                   flash_erase,
    output logic                   flash_err_rst,
    output logic                   irq
);
    import flg_pkg::*;

    // event positions are fixed, so the status word must hold all of them
    if (NUM_EV < `FLG_NUM_EV || NUM_EV > 32) begin : g_chk_num_ev
        $error("flg_guard: NUM_EV must lie between 4 and 32");
    end

    // a page number and an in-page offset must fill the flash address exactly
    if (`FLG_PAGE_SH + `FLG_PAGE_W != `FLG_ADDR_W) begin : g_chk_geom
        $error("flg_guard: page geometry does not fill the address");
    end

    // the reserved page rule is checked first and would shadow the lock page rules if they met
    if (`FLG_LOCK_PAGE == `FLG_RESV_PAGE) begin : g_chk_pages
        $error("flg_guard: lock page and reserved page coincide");
    end

    flg_chk_if chk ();

    flg_perm_check u_chk (
        .c (chk)
    );

    // bus state
    logic                     ph_wr_q,   ph_wr_d;
    logic                     ph_rd_d;
    logic [7:0]               ph_idx_q,  ph_idx_d;
    logic [31:0]              hrdata_q,  hrdata_d;
    logic                     hready_q,  hready_d;
    logic                     hresp_q,   hresp_d;

    // registers
    logic [7:0]               program_store_control_q,   program_store_control_d;
    logic [NUM_EV-1:0]        stat_q,    stat_d;
    logic [NUM_EV-1:0]        mask_q,    mask_d;
    logic [7:0]               lock_q,    lock_d;
    flg_addr_t                vaddr_q,   vaddr_d;

    // access outputs
    logic                     done_q,    done_d;
    logic                     grant_q,   grant_d;
    logic                     iserase_q, iserase_d;
    flg_addr_t                faddr_q,   faddr_d;
    logic [7:0]               fwdata_q,  fwdata_d;
    logic                     frd_q,     frd_d;
    logic                     fwr_q,     fwr_d;
    logic                     fer_q,     fer_d;
    logic                     errrst_q,  errrst_d;
    logic                     irq_q,     irq_d;

    logic                     addr_ph;
    logic                     wr_en;
    logic                     ee_en;
    logic [NUM_EV-1:0]        ev;
    logic                     stat_wr;
    flg_op_t                  op;

    assign addr_ph = hsel && hready && htrans[1];
    assign wr_en   = program_store_control_q[`FLG_BIT_WE];
    assign ee_en   = program_store_control_q[`FLG_BIT_EE];

    // a write with erase enabled becomes an erase of the whole page
    always_comb begin
        op = FLG_OP_READ;
        if (acc_is_write) begin
            op = ee_en ? FLG_OP_ERASE : FLG_OP_WRITE;
        end
    end

    assign chk.op        = op;
    assign chk.addr      = acc_addr;
    assign chk.wdata     = acc_wdata;
    assign chk.exec_page = exec_page;
    assign chk.lock_byte = lock_q;

    always_comb begin
        ph_wr_d  = addr_ph && hwrite;
        ph_rd_d  = addr_ph && !hwrite;
        ph_idx_d = addr_ph ? haddr[9:2] : ph_idx_q;
        hrdata_d = 32'h0000_0000;
        if (ph_rd_d) begin
            unique case (haddr[9:2])
                // next values, so a read right behind a write sees the new word
                `FLG_IDX_PROGRAM_STORE_CONTROL:     hrdata_d = {24'h000000, program_store_control_d};
                `FLG_IDX_STATUS:    hrdata_d = 32'(stat_d);
                `FLG_IDX_MASK:      hrdata_d = 32'(mask_d);
                `FLG_IDX_LOCK:      hrdata_d = {24'h000000, lock_q};
                `FLG_IDX_VIOL_ADDR: hrdata_d = {19'h00000, vaddr_q};
                default:            hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        ev        = '0;
        done_d    = 1'b0;
        grant_d   = grant_q;
        iserase_d = iserase_q;
        faddr_d   = faddr_q;
        fwdata_d  = fwdata_q;
        frd_d     = 1'b0;
        fwr_d     = 1'b0;
        fer_d     = 1'b0;
        errrst_d  = 1'b0;
        lock_d    = lock_q;
        vaddr_d   = vaddr_q;
        // writes without write enable are dropped silently, not faulted
        if (acc_valid) begin
            done_d    = 1'b1;
            iserase_d = (op == FLG_OP_ERASE);
            faddr_d   = acc_addr;
            fwdata_d  = acc_wdata;
            ev[`FLG_EV_DONE] = 1'b1;
            if (acc_is_write && !wr_en) begin
                grant_d = 1'b0;
            end else if (chk.allow) begin
                grant_d = 1'b1;
                frd_d   = (op == FLG_OP_READ);
                fwr_d   = (op == FLG_OP_WRITE);
                fer_d   = (op == FLG_OP_ERASE);
            end else begin
                grant_d  = 1'b0;
                errrst_d = 1'b1;
                vaddr_d  = acc_addr;
                ev[`FLG_EV_VIOL]      = 1'b1;
                ev[`FLG_EV_RESV]      = chk.resv_hit;
                ev[`FLG_EV_LOCKERASE] = chk.lock_erase;
            end
        end
    end

    // control and mask writes land at the end of the data phase
    always_comb begin
        program_store_control_d = program_store_control_q;
        mask_d  = mask_q;
        if (ph_wr_q) begin
            unique case (ph_idx_q)
                `FLG_IDX_PROGRAM_STORE_CONTROL: program_store_control_d = {6'h00, hwdata[1:0]};
                `FLG_IDX_MASK:  mask_d  = hwdata[NUM_EV-1:0];
                default:        program_store_control_d = program_store_control_q;
            endcase
        end
    end

    // status is write-one-to-clear; its data phase is decoded once for all bits
    assign stat_wr = ph_wr_q && (ph_idx_q == `FLG_IDX_STATUS);

    // one sticky bit per event; an event in the clearing cycle wins, so none is lost
    for (genvar i = 0; i < NUM_EV; i++) begin : g_stat
        always_comb begin
            stat_d[i] = stat_q[i];
            if (stat_wr && hwdata[i]) begin
                stat_d[i] = 1'b0;
            end
            if (ev[i]) begin
                stat_d[i] = 1'b1;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                stat_q[i] <= 1'b0;
            end else begin
                stat_q[i] <= stat_d[i];
            end
        end
    end

    // level interrupt moves on the same edge as the status bits
    assign irq_d = |(stat_d & mask_d);

    // zero wait states and an OKAY answer for every transfer
    assign hready_d = 1'b1;
    assign hresp_d  = 1'b0;

    // bus interface flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_q  <= 1'b0;
            ph_idx_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
        end else begin
            ph_wr_q  <= ph_wr_d;
            ph_idx_q <= ph_idx_d;
            hrdata_q <= hrdata_d;
            hready_q <= hready_d;
            hresp_q  <= hresp_d;
        end
    end

    // control registers, lock byte and interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_store_control_q <= `FLG_PROGRAM_STORE_CONTROL_RST;
            mask_q  <= '0;
            lock_q  <= LOCK_IMAGE;
            vaddr_q <= '0;
            irq_q   <= 1'b0;
        end else begin
            program_store_control_q <= program_store_control_d;
            mask_q  <= mask_d;
            lock_q  <= lock_d;
            vaddr_q <= vaddr_d;
            irq_q   <= irq_d;
        end
    end

    // verdict flops: done and the strobes are single-cycle pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q    <= 1'b0;
            grant_q   <= 1'b0;
            iserase_q <= 1'b0;
            frd_q     <= 1'b0;
            fwr_q     <= 1'b0;
            fer_q     <= 1'b0;
            errrst_q  <= 1'b0;
        end else begin
            done_q    <= done_d;
            grant_q   <= grant_d;
            iserase_q <= iserase_d;
            frd_q     <= frd_d;
            fwr_q     <= fwr_d;
            fer_q     <= fer_d;
            errrst_q  <= errrst_d;
        end
    end

    // request capture: the flash sees exactly the address and data that were judged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            faddr_q  <= '0;
            fwdata_q <= 8'h00;
        end else begin
            faddr_q  <= faddr_d;
            fwdata_q <= fwdata_d;
        end
    end

    assign hrdata        = hrdata_q;
    assign hreadyout     = hready_q;
    assign hresp         = hresp_q;
    assign acc_done      = done_q;
    assign acc_granted   = grant_q;
    assign acc_is_erase  = iserase_q;
    assign flash_addr    = faddr_q;
    assign flash_wdata   = fwdata_q;
    assign flash_rd      = frd_q;
    assign flash_wr      = fwr_q;
    assign flash_erase   = fer_q;
    assign flash_err_rst = errrst_q;
    assign irq           = irq_q;
endmodule : flg_guard

// *** inc/flg_defs.svh ***
// flg_defs.svh: register offsets, field positions, reset values and sizes of the flash lock guard
// assumes a 32-bit AHB-Lite register window; included by bare name
`ifndef FLG_DEFS_SVH
`define FLG_DEFS_SVH

// printed offset 0x8F is not a multiple of four, so it is an index: byte address = 4 * index
`define FLG_IDX_PROGRAM_STORE_CONTROL      8'h8F
`define FLG_IDX_STATUS     8'h90
`define FLG_IDX_MASK       8'h91
`define FLG_IDX_LOCK       8'h92
`define FLG_IDX_VIOL_ADDR  8'h93

`define FLG_BIT_WE         0
`define FLG_BIT_EE         1
`define FLG_PROGRAM_STORE_CONTROL_RST      8'h00
`define FLG_LOCK_RST       8'hFF

// status and mask layout
`define FLG_EV_VIOL        0
`define FLG_EV_RESV        1
`define FLG_EV_LOCKERASE   2
`define FLG_EV_DONE        3
`define FLG_NUM_EV         4

`define FLG_ADDR_W         13
`define FLG_PAGE_W         4
`define FLG_PAGE_SH        9
`define FLG_LOCK_PAGE      4'hE
`define FLG_RESV_PAGE      4'hF
`define FLG_LOCK_OFS       9'h1FF

`endif

// *** inc/flg_pkg.sv ***
// flg_pkg: types shared by the flash lock guard modules
// assumes flg_defs.svh is on the include path
`include "flg_defs.svh"
package flg_pkg;
    typedef enum logic [1:0] {
        FLG_OP_READ,
        FLG_OP_WRITE,
        FLG_OP_ERASE
    } flg_op_t;

    typedef logic [`FLG_ADDR_W-1:0] flg_addr_t;
    typedef logic [`FLG_PAGE_W-1:0] flg_page_t;
endpackage : flg_pkg

// *** inc/flg_chk_if.sv ***
// flg_chk_if: request and verdict between the guard top and its permission checker
// assumes a single clock; the checker is purely combinational
`timescale 1ns/1ps
interface flg_chk_if;
    import flg_pkg::*;
    flg_op_t    op;
    flg_addr_t  addr;
    logic [7:0] wdata;
    flg_page_t  exec_page;
    logic [7:0] lock_byte;
    logic       allow;
    logic       resv_hit;
    logic       lock_erase;

    modport req (output op, addr, wdata, exec_page, lock_byte,
                 input allow, resv_hit, lock_erase);
    modport chk (input op, addr, wdata, exec_page, lock_byte,
                 output allow, resv_hit, lock_erase);
endinterface : flg_chk_if

// *** rtl/flg_perm_check.sv ***
// flg_perm_check: decides whether one flash access is allowed
// assumes page 14 holds the lock byte, page 15 is reserved, lock bit 0 means locked
`timescale 1ns/1ps
`include "flg_defs.svh"
module flg_perm_check (
    flg_chk_if.chk c
);
    import flg_pkg::*;

    flg_page_t tgt_page;
    logic      tgt_locked;
    logic      exec_locked;
    logic      is_lock_page;
    logic      is_lock_byte;

    always_comb begin
        tgt_page     = c.addr[`FLG_ADDR_W-1:`FLG_PAGE_SH];
        // pages beyond lock byte width count as unlocked
        tgt_locked   = (tgt_page < 4'd8) ? ~c.lock_byte[tgt_page[2:0]] : 1'b0;
        exec_locked  = (c.exec_page < 4'd8) ? ~c.lock_byte[c.exec_page[2:0]] : 1'b0;
        is_lock_page = (tgt_page == `FLG_LOCK_PAGE);
        is_lock_byte = is_lock_page && (c.addr[`FLG_PAGE_SH-1:0] == `FLG_LOCK_OFS);
        c.resv_hit   = (tgt_page == `FLG_RESV_PAGE);
        c.lock_erase = is_lock_page && (c.op == FLG_OP_ERASE);
        c.allow      = 1'b0;
        if (c.resv_hit || c.lock_erase) begin
            c.allow = 1'b0;
        end else if (is_lock_byte && c.op == FLG_OP_READ) begin
            c.allow = 1'b1;
        end else if (is_lock_byte && c.op == FLG_OP_WRITE) begin
            // any change of lock bits in either direction is refused
            c.allow = (c.wdata == c.lock_byte) &&
                      (exec_locked || !tgt_locked);
        end else if (exec_locked) begin
            c.allow = 1'b1;
        end else if (is_lock_page) begin
            c.allow = !tgt_locked;
        end else begin
            c.allow = !tgt_locked;
        end
    end
endmodule : flg_perm_check

// *** sim/flg_guard_properties.sv ***
// flg_guard_properties: port-level checks of the flash lock guard verdicts
// assumes it is bound into flg_guard; pages 8 to 13 lie beyond the lock byte
`timescale 1ns/1ps
module flg_guard_properties (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               acc_valid,
    input wire logic               acc_is_write,
    input wire flg_pkg::flg_addr_t acc_addr,
    input wire logic               acc_done,
    input wire logic               acc_granted,
    input wire logic               acc_is_erase,
    input wire flg_pkg::flg_addr_t flash_addr,
    input wire logic               flash_rd,
    input wire logic               flash_wr,
    input wire logic               flash_erase,
    input wire logic               flash_err_rst
);
    import flg_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_rd_req;
        acc_valid && !acc_is_write;
    endsequence
    sequence s_lock_rd;
        s_rd_req ##0 acc_addr == 13'h1DFF;
    endsequence
    a_free_read: assert property (
        s_rd_req ##0 acc_addr[12:9] inside {[4'h8:4'hD]} |=> acc_done && acc_granted && flash_rd)
        else $error("unlocked page read refused");
    a_strobe_granted: assert property (
        flash_rd || flash_wr || flash_erase |-> acc_granted && acc_done)
        else $error("strobe without grant");
    a_lock_read: assert property (
        s_lock_rd |=> acc_granted && flash_rd && !flash_err_rst)
        else $error("lock byte read refused");
    a_no_lock_erase: assert property (
        flash_erase |-> flash_addr[12:9] != 4'hE)
        else $error("lock page erased");
    a_resv_reset: assert property (
        acc_valid && acc_addr[12:9] == 4'hF |=> flash_err_rst && !acc_granted)
        else $error("reserved access not reset");
    a_err_quiet: assert property (
        flash_err_rst |-> acc_done && !(flash_rd || flash_wr || flash_erase))
        else $error("strobe with error reset");
    a_write_cause: assert property (
        flash_wr || flash_erase |-> $past(acc_valid && acc_is_write))
        else $error("write strobe without write request");
    a_erase_kind: assert property (
        flash_erase |-> acc_is_erase && !flash_wr)
        else $error("erase strobe inconsistent");
endmodule : flg_guard_properties

// *** sim/flg_core_model.sv ***
// flg_core_model: processor core issuing one flash access at a time
// assumes the verdict arrives within eight cycles of the request pulse
`timescale 1ns/1ps
module flg_core_model (
    input  wire logic         hclk,
    input  wire logic         acc_done,
    input  wire logic         acc_granted,
    input  wire logic         flash_rd,
    input  wire logic         flash_wr,
    input  wire logic         flash_erase,
    input  wire logic         flash_err_rst,
    output logic              acc_valid,
    output logic              acc_is_write,
    output flg_pkg::flg_addr_t acc_addr,
    output logic [7:0]        acc_wdata,
    output flg_pkg::flg_page_t exec_page
);
    import flg_pkg::*;
    initial begin
        acc_valid = 1'b0;
        acc_is_write = 1'b0;
        acc_addr = '0;
        acc_wdata = 8'h00;
        exec_page = 4'h0;
    end
    // result packs granted, read, write, erase, error reset
    task automatic access(input logic w, input flg_addr_t a, input logic [7:0] dat,
                          input flg_page_t pg, output logic [4:0] res);
        int n;
        n = 0;
        @(posedge hclk);
        acc_valid <= 1'b1;
        acc_is_write <= w;
        acc_addr <= a;
        acc_wdata <= dat;
        exec_page <= pg;
        @(posedge hclk);
        acc_valid <= 1'b0;
        // released lines must not look like a still-valid request
        acc_addr <= ~a;
        acc_wdata <= ~dat;
        @(posedge hclk);
        while (acc_done !== 1'b1 && n < 8) begin
            @(posedge hclk);
            n++;
        end
        res = (n < 8) ? {acc_granted, flash_rd, flash_wr, flash_erase, flash_err_rst} : 5'h1F;
    endtask : access
endmodule : flg_core_model

// *** sim/flg_guard_test.sv ***
// flg_guard_test: self-checking bench of the flash lock guard
// assumes a core model drives the access port and the bench is the bus master
`timescale 1ns/1ps
module flg_guard_test;
    import flg_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        acc_valid, acc_is_write, acc_done, acc_granted, acc_is_erase;
    logic        flash_rd, flash_wr, flash_erase, flash_err_rst;
    flg_addr_t   acc_addr, flash_addr;
    flg_page_t   exec_page;
    logic [7:0]  acc_wdata, flash_wdata;
    logic [4:0]  r;
    localparam logic [7:0] LOCK_IMG = 8'hF0; // pages 0 to 3 locked, 4 to 7 open
    int          num_errors, total_checks, cycles;
    assign hready = hreadyout;
    flg_guard #(.LOCK_IMAGE(LOCK_IMG)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .acc_valid(acc_valid),
        .acc_is_write(acc_is_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .exec_page(exec_page), .acc_done(acc_done), .acc_granted(acc_granted),
        .acc_is_erase(acc_is_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_erase(flash_erase),
        .flash_err_rst(flash_err_rst), .irq(irq));
    flg_core_model core (.hclk(hclk), .acc_done(acc_done), .acc_granted(acc_granted),
        .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_erase(flash_erase),
        .flash_err_rst(flash_err_rst), .acc_valid(acc_valid), .acc_is_write(acc_is_write),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .exec_page(exec_page));
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask : bus
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic t_regs;
        bus(1'b0, 32'h23C, 32'h0);
        chk("program_store_control reset", d, 32'h0);
        bus(1'b0, 32'h248, 32'h0);
        chk("lock byte reset", d, LOCK_IMG);
        chk("bus response", hresp, 32'h0);
        bus(1'b0, 32'h000, 32'h0);
        chk("unmapped read", d, 32'h0);
        bus(1'b1, 32'h23C, 32'h3);
        bus(1'b0, 32'h23C, 32'h0);
        chk("program_store_control readback", d, 32'h3);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_gate;
        bus(1'b1, 32'h23C, 32'h0);
        core.access(1'b1, 13'h1200, 8'hA5, 4'h0, r);
        chk("write gated", r, 5'h00);
        bus(1'b1, 32'h23C, 32'h1);
        core.access(1'b1, 13'h1200, 8'hA5, 4'h4, r);
        chk("write granted", r, 5'h14);
        chk("flash address", flash_addr, 32'h1200);
        chk("flash data", flash_wdata, 32'hA5);
        bus(1'b1, 32'h23C, 32'h3);
        core.access(1'b1, 13'h1300, 8'h00, 4'h0, r);
        chk("page erase", r, 5'h12);
        chk("erase kind", acc_is_erase, 32'h1);
        core.access(1'b0, 13'h1000, 8'h00, 4'hE, r);
        chk("read page 8", r, 5'h18);
        $display("t_gate done");
    endtask : t_gate
    task automatic t_lock;
        bus(1'b1, 32'h23C, 32'h1);
        core.access(1'b0, 13'h1DFF, 8'h00, 4'h3, r);
        chk("lock byte read", r, 5'h18);
        core.access(1'b1, 13'h1C00, 8'h55, 4'h3, r);
        chk("lock page write", r, 5'h14);
        core.access(1'b1, 13'h1C00, 8'h55, 4'h4, r);
        chk("lock page open code", r, 5'h14);
        core.access(1'b0, 13'h0200, 8'h00, 4'h4, r);
        chk("locked page open code", r, 5'h01);
        core.access(1'b0, 13'h0200, 8'h00, 4'h0, r);
        chk("locked page locked code", r, 5'h18);
        core.access(1'b1, 13'h1DFF, LOCK_IMG, 4'h3, r);
        chk("lock byte same value", r, 5'h14);
        core.access(1'b1, 13'h1DFF, 8'h7F, 4'h3, r);
        chk("lock byte change", {r[4], r[2]}, 32'h0);
        core.access(1'b1, 13'h1DFF, 8'hFF, 4'h3, r);
        chk("lock byte unlock", r, 5'h01);
        bus(1'b0, 32'h248, 32'h0);
        chk("lock byte kept", d, LOCK_IMG);
        bus(1'b1, 32'h23C, 32'h3);
        core.access(1'b1, 13'h1C10, 8'h00, 4'hE, r);
        chk("lock erase from lock page", r, 5'h01);
        core.access(1'b1, 13'h1C10, 8'h00, 4'h2, r);
        chk("lock erase from other page", r, 5'h01);
        $display("t_lock done");
    endtask : t_lock
    task automatic t_resv;
        bus(1'b1, 32'h240, 32'hF);
        bus(1'b1, 32'h244, 32'h2);
        chk("irq idle", irq, 32'h0);
        core.access(1'b0, 13'h1E00, 8'h00, 4'h0, r);
        chk("reserved read", r, 5'h01);
        bus(1'b0, 32'h240, 32'h0);
        chk("reserved status", d, 32'hB);
        chk("irq raised", irq, 32'h1);
        bus(1'b0, 32'h24C, 32'h0);
        chk("violation address", d, 32'h1E00);
        bus(1'b1, 32'h240, 32'h2);
        bus(1'b1, 32'h244, 32'h0);
        core.access(1'b1, 13'h1E00, 8'h00, 4'h0, r);
        bus(1'b0, 32'h240, 32'h0);
        chk("irq masked", irq, 32'h0);
        $display("t_resv done");
    endtask : t_resv
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, cycles} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_gate();
        t_lock();
        t_resv();
        test_done();
    end
endmodule : flg_guard_test
bind flg_guard flg_guard_properties u_props (.hclk(hclk), .hresetn(hresetn),
    .acc_valid(acc_valid), .acc_is_write(acc_is_write), .acc_addr(acc_addr),
    .acc_done(acc_done), .acc_granted(acc_granted), .acc_is_erase(acc_is_erase),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_wr(flash_wr),
    .flash_erase(flash_erase), .flash_err_rst(flash_err_rst));
